// file: hw/mrpc_top.sv
`timescale 1ns/1ps
module mrpc_top
  import mrpc_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  input  wire logic       ce_in,
  input  wire logic       oscillator_input_in,
  input  wire logic       ext_reset_in,
  input  wire logic       irq_pending_in,
  input  wire mrpc_ctl_t  ctl_in,
  output logic            int_clk_out,
  output mrpc_clk_t       clk_out,
  output logic [7:0]      power_control_register_out,
  output logic [7:0]      port_latch_out,
  output logic [7:0]      stack_ptr_out,
  output logic            sfr_clear_out,
  output logic            ale_oe_n_out,
  output logic            program_fetch_strobe_oe_n_out,
  output mrpc_mode_t      mode_out
);
  localparam int PW = $clog2(MRPC_PHASES);
  localparam int FW = $clog2(MRPC_FILTER_CYCLES + 1);

  typedef struct packed {
    logic              osc_prev;
    logic              int_clk;
    logic [PW-1:0]     phase;
    logic [FW-1:0]     agree;
    logic              rst_clean;
    logic [7:0]        pwr_ctl;
    logic [7:0]        ports;
    logic [7:0]        sp;
    mrpc_mode_t        mode;
    mrpc_clk_t         clk;
    logic              strobe_oe_n;
  } mrpc_state_t;

  mrpc_state_t st;
  mrpc_state_t next_st;
  logic        osc_s;
  logic        rst_s;
  logic        osc_rise;
  logic        osc_edge;

  // oscillator and reset pins pass two flops before any logic looks at them
  mrpc_sync u_osc_sync (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .ce_in      (ce_in),
    .d_in       (oscillator_input_in),
    .q_out      (osc_s)
  );

  mrpc_sync u_rst_sync (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .ce_in      (ce_in),
    .d_in       (ext_reset_in),
    .q_out      (rst_s)
  );

  // rising edges of the oscillator input; a halted input simply gives none
  assign osc_rise = osc_s & ~st.osc_prev;
  assign osc_edge = osc_rise & st.clk.osc_en;

  always_comb begin
    next_st          = st;
    next_st.osc_prev = osc_s;
    if (osc_edge) begin
      next_st.int_clk = ~st.int_clk;
    end
    // the reset sampler keeps its timing in power-down as well: only a
    // reset may end that mode, so the pin must still be looked at
    if (osc_rise) begin
      // phase counts oscillator periods within one machine cycle
      if (st.phase == PW'(MRPC_PHASES - 1)) begin
        next_st.phase = '0;
      end else begin
        next_st.phase = st.phase + PW'(1);
      end
      // one sample per machine cycle; filter needs repeated agreement
      if (st.phase == PW'(MRPC_SAMPLE_PHASE)) begin
        if (rst_s != st.rst_clean) begin
          if (st.agree == FW'(MRPC_FILTER_CYCLES - 1)) begin
            next_st.rst_clean = rst_s;
            next_st.agree     = '0;
          end else begin
            next_st.agree = st.agree + FW'(1);
          end
        end else begin
          next_st.agree = '0; // a glitch restarts the count
        end
      end
    end

    if (st.rst_clean) begin
      // reset wins over every mode, including power-down
      next_st.ports       = MRPC_PORT_RST;
      next_st.sp          = MRPC_SP_RST;
      next_st.pwr_ctl     = (st.pwr_ctl & MRPC_PWR_KEEP)
                            | (MRPC_SFR_RST & ~MRPC_PWR_KEEP);
      next_st.mode        = MRPC_RUN;
      next_st.strobe_oe_n = 1'b1;
      next_st.clk.osc_en  = 1'b1;
    end else begin
      next_st.strobe_oe_n = 1'b0;
      if (ctl_in.pwr_wr && st.mode == MRPC_RUN) begin
        next_st.pwr_ctl = ctl_in.pwr_wdata;
      end
      unique case (st.mode)
        MRPC_RUN: begin
          if (ctl_in.powerdown_request_bit) begin
            next_st.mode                    = MRPC_DOWN;
            next_st.pwr_ctl[MRPC_DOWN_BIT]  = 1'b1;
          end else if (ctl_in.idle_request_bit) begin
            next_st.mode                    = MRPC_IDLE;
            next_st.pwr_ctl[MRPC_IDLE_BIT]  = 1'b1;
          end
        end
        MRPC_IDLE: begin
          if (irq_pending_in) begin
            next_st.mode                    = MRPC_RUN;
            next_st.pwr_ctl[MRPC_IDLE_BIT]  = 1'b0;
          end
        end
        MRPC_DOWN: begin
          next_st.mode = MRPC_DOWN; // interrupts ignored here
        end
      endcase
    end

    // clock gates follow the mode of the coming cycle
    next_st.clk.sys_reset  = next_st.rst_clean;
    next_st.clk.cpu_clk_en = (next_st.mode == MRPC_RUN);
    next_st.clk.per_clk_en = (next_st.mode != MRPC_DOWN);
    next_st.clk.osc_en     = (next_st.mode != MRPC_DOWN)
                             || next_st.rst_clean;
  end

  // clock enable low freezes everything; a stopped oscillator freezes only internal clock and reset timing
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st                 <= '0;
      st.ports           <= MRPC_PORT_RST;
      st.sp              <= MRPC_SP_RST;
      st.mode            <= MRPC_RUN;
      st.clk.osc_en      <= 1'b1;
      st.clk.cpu_clk_en  <= 1'b1;
      st.clk.per_clk_en  <= 1'b1;
      st.strobe_oe_n     <= 1'b1;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign int_clk_out                   = st.int_clk;
  assign clk_out                       = st.clk;
  assign power_control_register_out    = st.pwr_ctl;
  assign port_latch_out                = st.ports;
  assign stack_ptr_out                 = st.sp;
  assign sfr_clear_out                 = st.rst_clean;
  assign ale_oe_n_out                  = st.strobe_oe_n;
  assign program_fetch_strobe_oe_n_out = st.strobe_oe_n;
  assign mode_out                      = st.mode;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in || !ce_in);

  down_sticky_a: assert property (
    (st.mode == MRPC_DOWN && !st.rst_clean) |=> st.mode == MRPC_DOWN)
    else $error("power-down left without reset");
  idle_wake_a: assert property (
    (st.mode == MRPC_IDLE && irq_pending_in && !st.rst_clean)
    |=> st.mode == MRPC_RUN && !st.pwr_ctl[MRPC_IDLE_BIT])
    else $error("idle not woken");
  cpu_gate_a: assert property (
    (st.mode == MRPC_IDLE) |-> !st.clk.cpu_clk_en && st.clk.per_clk_en)
    else $error("idle clock gates wrong");
  osc_stop_a: assert property (
    (st.mode == MRPC_DOWN && !st.rst_clean)
    |-> !st.clk.osc_en && !st.clk.per_clk_en)
    else $error("clocks run in power-down");
  rst_values_a: assert property (
    st.rst_clean |=> st.ports == MRPC_PORT_RST && st.sp == MRPC_SP_RST)
    else $error("reset values wrong");
  pwr_keep_a: assert property (
    st.rst_clean |=> (st.pwr_ctl & ~MRPC_PWR_KEEP) == MRPC_SFR_RST
    && (st.pwr_ctl & MRPC_PWR_KEEP) == ($past(st.pwr_ctl) & MRPC_PWR_KEEP))
    else $error("power control reset wrong");
  strobe_float_a: assert property (
    st.rst_clean |=> st.strobe_oe_n)
    else $error("strobes driven in reset");
  half_clk_a: assert property (
    !osc_edge |=> $stable(st.int_clk))
    else $error("internal clock moved without edge");
  filter_a: assert property (
    $changed(st.rst_clean) |-> $past(st.phase) == PW'(MRPC_SAMPLE_PHASE))
    else $error("reset changed off the sample phase");

  idle_c: cover property (st.mode == MRPC_IDLE ##1 st.mode == MRPC_RUN);
  down_c: cover property (st.mode == MRPC_DOWN ##[1:50] st.rst_clean);
  rst_c:  cover property ($rose(st.rst_clean));
endmodule

// file: hw/mrpc_pkg.sv
// What this block does
// - internal clock is oscillator input halved
// - idle request stops processor clock only
// - idle ends on enabled interrupt or reset
// - power-down request stops every clock, oscillator too
// - power-down left only through reset
// - reset pin sampled once per machine cycle, state five
// - reset input filtered against glitches
// - reset sets ports to ones, stack pointer seven
// - reset clears power control, keeps bit four
// - reset clears other registers, serial buffer kept
// - strobes float high during reset
// - halted oscillator input keeps internal clock, phase and reset filter state
package mrpc_pkg;
  localparam int  MRPC_PHASES        = 12;  // oscillator phases per machine cycle
  localparam int  MRPC_SAMPLE_PHASE  = 9;   // state five, second phase
  localparam int  MRPC_FILTER_CYCLES = 2;   // machine cycles of agreement
  localparam logic [7:0] MRPC_PORT_RST = 8'hff;
  localparam logic [7:0] MRPC_SP_RST   = 8'h07;
  localparam logic [7:0] MRPC_SFR_RST  = 8'h00;
  localparam logic [7:0] MRPC_PWR_KEEP = 8'h10; // bit four survives reset
  localparam int  MRPC_IDLE_BIT = 0;
  localparam int  MRPC_DOWN_BIT = 1;

  typedef enum logic [1:0] {MRPC_RUN, MRPC_IDLE, MRPC_DOWN} mrpc_mode_t;

  typedef struct packed {
    logic idle_request_bit;
    logic powerdown_request_bit;
    logic pwr_wr;
    logic [7:0] pwr_wdata;
  } mrpc_ctl_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic per_clk_en;
    logic osc_en;
    logic sys_reset;
  } mrpc_clk_t;
endpackage

// file: hw/mrpc_sync.sv
`timescale 1ns/1ps
module mrpc_sync
  import mrpc_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  input  wire logic d_in,
  output logic      q_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } mrpc_sync_t;
  mrpc_sync_t st;
  mrpc_sync_t next_st;

  // two flops; first is read only by the second
  always_comb begin
    next_st    = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign q_out = st.s2;
endmodule

// file: dv/mrpc_far_side.sv
`timescale 1ns/1ps
module mrpc_far_side (
  input  wire logic       clk_in,
  input  wire logic       osc_run_in,
  input  wire logic       go_in,
  input  wire logic [7:0] len_in,
  output logic            osc_out,
  output logic            rst_out
);
  logic [1:0] div   = 2'h0;
  logic [7:0] left  = 8'h0;
  logic       osc_q = 1'b0;
  initial osc_out = 1'b0;
  // oscillator freezes at whatever level it had when halted
  always @(posedge clk_in) begin
    osc_q <= osc_out;
    if (osc_run_in) begin
      div <= div + 2'h1;
      if (div == 2'h1) osc_out <= ~osc_out;
    end
    if (go_in) left <= len_in;
    else if (osc_out && !osc_q && left != 8'h0) left <= left - 8'h1;
  end
  // reset length counted in oscillator periods; rc network pulls low after
  assign rst_out = (left != 8'h0);
endmodule

// file: dv/mrpc_top_bench.sv
`timescale 1ns/1ps
module mrpc_top_bench;
  import mrpc_pkg::*;
  logic       sys_clk_in = 1'b0;
  logic       srst_in    = 1'b1;
  logic       ce_in      = 1'b1;
  logic       irq        = 1'b0;
  logic       osc_run    = 1'b1;
  logic       go         = 1'b0;
  logic [7:0] len        = 8'h0;
  mrpc_ctl_t  ctl        = '0;
  logic       osc, ext_rst, int_clk, sfr_clr, ale_n, pfs_n;
  mrpc_clk_t  en;
  logic [7:0] pwr, ports, sp;
  mrpc_mode_t mode;
  int         failures   = 0;
  int         num_checks = 0;
  int         cycles     = 0;

  always #10 sys_clk_in = ~sys_clk_in;

  mrpc_far_side i_far (.clk_in(sys_clk_in), .osc_run_in(osc_run),
    .go_in(go), .len_in(len), .osc_out(osc), .rst_out(ext_rst));

  mrpc_top i_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .oscillator_input_in(osc), .ext_reset_in(ext_rst),
    .irq_pending_in(irq), .ctl_in(ctl), .int_clk_out(int_clk),
    .clk_out(en), .power_control_register_out(pwr),
    .port_latch_out(ports), .stack_ptr_out(sp), .sfr_clear_out(sfr_clr),
    .ale_oe_n_out(ale_n), .program_fetch_strobe_oe_n_out(pfs_n),
    .mode_out(mode));

  task automatic end_sim;
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  // one go strobe; the far side then times the reset itself
  task automatic fire_rst(input logic [7:0] n);
    go = 1'b1;
    len = n;
    cyc(1);
    go = 1'b0;
  endtask

  task automatic wait_clr(input logic v);
    int k;
    k = 0;
    while (sfr_clr !== v && k < 1000) begin
      cyc(1);
      k++;
    end
  endtask

  // fl is the expected output-enable level: high only while the pin
  // reset is in force, the strobes are driven otherwise
  task automatic chk_rst(input logic [7:0] pc, input logic fl);
    chk(ports === MRPC_PORT_RST && sp === MRPC_SP_RST, "port/sp");
    chk(pwr === pc, "power control after reset");
    chk(ale_n === fl && pfs_n === fl, "strobe float level");
  endtask

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("CHECK FAILED %0t timeout", $time);
      end_sim();
    end
  end

  initial begin
    logic       po, pi, seen;
    int         no, ni, i;
    logic [7:0] w, p;
    void'($urandom(32'h117f));
    cyc(2);
    srst_in = 1'b0;
    cyc(100);
    chk_rst(MRPC_SFR_RST, 1'b0);
    // count oscillator rises against internal clock toggles
    no = 0;
    ni = 0;
    po = osc;
    pi = int_clk;
    repeat (400) begin
      cyc(1);
      if (osc && !po) no++;
      if (int_clk !== pi) ni++;
      po = osc;
      pi = int_clk;
    end
    chk(no > 40 && ni - no <= 1 && no - ni <= 1, "half rate");
    ctl.idle_request_bit = 1'b1;
    cyc(2);
    ctl.idle_request_bit = 1'b0;
    cyc($urandom_range(20, 1));
    chk(mode === MRPC_IDLE && en.cpu_clk_en === 1'b0 &&
        en.per_clk_en === 1'b1 && pwr[MRPC_IDLE_BIT] === 1'b1, "idle");
    irq = 1'b1;
    cyc(2);
    irq = 1'b0;
    chk(mode === MRPC_RUN && en.cpu_clk_en === 1'b1 &&
        pwr[MRPC_IDLE_BIT] === 1'b0, "idle wake");
    ctl.idle_request_bit = 1'b1;
    ctl.powerdown_request_bit = 1'b1;
    cyc(2);
    ctl = '0;
    chk(mode === MRPC_DOWN && en.cpu_clk_en === 1'b0 &&
        en.per_clk_en === 1'b0 && en.osc_en === 1'b0, "power-down");
    irq = 1'b1;
    cyc(50);
    irq = 1'b0;
    chk(mode === MRPC_DOWN, "irq woke power-down");
    // resets of 3 machine cycles; 6 periods spans one sample at most
    for (i = 0; i < 2; i++) begin
      w = 8'($urandom) & 8'hfc;
      ctl.pwr_wr = (i == 1);
      ctl.pwr_wdata = w;
      cyc(1);
      ctl = '0;
      p = (i == 1) ? w : pwr;
      fire_rst(8'h24);
      wait_clr(1'b1);
      cyc(2);
      chk(sfr_clr === 1'b1 && en.sys_reset === 1'b1, "no reset");
      chk_rst(p & MRPC_PWR_KEEP, 1'b1);
      wait_clr(1'b0);
      cyc(2);
      chk(mode === MRPC_RUN && sfr_clr === 1'b0, "reset exit");
    end
    seen = 1'b0;
    for (i = 0; i < 4; i++) begin
      fire_rst(8'($urandom_range(6, 1)));
      repeat (300) begin
        cyc(1);
        if (sfr_clr !== 1'b0) seen = 1'b1;
      end
    end
    chk(!seen, "glitch taken as reset");
    // halt the oscillator, also freeze with ce low under a pending request
    osc_run = 1'b0;
    p = pwr;
    pi = int_clk;
    ce_in = 1'b0;
    ctl.idle_request_bit = 1'b1;
    cyc($urandom_range(200, 100));
    chk(mode === MRPC_RUN && pwr === p && int_clk === pi, "halt");
    ctl = '0;
    ce_in = 1'b1;
    osc_run = 1'b1;
    cyc(50);
    end_sim();
  end
endmodule
